// *** emu_map_consts.vh ***
// Constants for the emulator memory map and run gating block.
// Assumes byte addresses on a 32-bit target bus and an AXI4-Lite register port.
`ifndef EMU_MAP_CONSTS_VH
`define EMU_MAP_CONSTS_VH

// Memory geometry
`define AREA_BITS          27
`define BLOCK_BITS         17
`define BLOCKS_PER_AREA    1024
`define EMU_MEM_BLOCKS     4
`define ATTR_ENTRIES       4096

// Address regions: top nibble 4'hf is on-chip I/O, 4'he on-chip RAM/ROM shadow
`define IO_REGION_TOP      4'hf
`define ONCHIP_REGION_TOP  4'he

// Register byte offsets
`define REG_RUN_CTRL       12'h000
`define REG_EXEC_MODE      12'h004
`define REG_STATUS         12'h008
`define REG_MAP_SEL        12'h00c
`define REG_MAP_DATA       12'h010
`define REG_HOST_ACC       12'h014
`define REG_TRIG           12'h018
`define REG_WDT            12'h01c
`define REG_FRT            12'h020

// Run states
`define RUN_WAIT           2'd0
`define RUN_FREE           2'd1
`define RUN_STEP           2'd2

// Exec mode bits
`define EM_MASK_USER_BUS_REQUEST_IN       0
`define EM_WAIT_EMU        1

// Map entry fields: [3] emu, [1:0] emu slot, [4] write protect, [5] guarded
`define ME_EMU             3
`define ME_WP              4
`define ME_GUARD           5
`define ME_W               6

// Host access command bits
`define HA_WRITE           0
`define HA_FILL            1

// Trigger pulse width in ns and cycles at 200 MHz
`define TRIG_NS            100
`define CLK_NS             5
`define TRIG_CYCLES        (`TRIG_NS / `CLK_NS)

`define AXI_OKAY           2'b00
`define AXI_SLVERR         2'b10

`endif

// *** emu_map_gate.v ***
// Memory mapping and run gating logic of an emulator pod, with an AXI4-Lite
// control port. Assumes the target bus is already in aclk's domain; user pins are
// synchronised here, except sleep_entry and break_in, which are used directly.
//
// Summary of operation
// R1: 512 kbyte emulation memory mapped in 128 kbyte blocks over four 128 Mbyte areas.
// R2: Emulation memory hits take programmed waits, and user wait only if extended.
// R3: Write-protect and guarded attributes assignable per 128 kbyte block.
// R4: Attributes act only on external addresses, never on on-chip regions.
// R5: On-chip I/O accesses always go to internal peripherals.
// R6: Host write to on-chip I/O warns and skips read-back verification.
// R7: Block fill aimed at on-chip I/O is refused.
// R8: Sleep ends by wake-up or break; no trace captured while asleep.
// R9: Resume after low-power break restarts after the sleep instruction.
// R10: Parallel-mode host memory access during sleep ends sleep, continues after it.
// R11: No interrupts in command wait; edge interrupts latched and run at free-run.
// R12: User reset reaches target only during free-run execution.
// R13: Wait and bus request pass only when running; bus request maskable.
// R14: Watchdog counts only while running, halts at break.
// R15: Free-running counter keeps counting always; host may rewrite it.
// R16: Serial interface active in wait and run; host write transmits.
// R17: DMA requests serviced in both run and command wait.
// R18: Programmed waits on all external memory, none on-chip; user wait only on user memory unless extended.
// R19: Refresh requests issued continuously, including command wait.
// R20: Trigger output emits a low-going pulse.
// R21: Protected writes suppressed; guarded accesses still select memory and raise break.
`timescale 1ns/1ps
`include "emu_map_consts.vh"

module emu_map_gate #(
	parameter TRIG_LEN = `TRIG_CYCLES
) (
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite slave
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Target bus cycle, same clock
	input  wire        tgt_req,
	input  wire        tgt_write,
	input  wire [31:0] tgt_addr,
	input  wire [3:0]  tgt_prog_waits,
	output reg         emu_sel,
	output reg  [1:0]  emu_slot,
	output reg         user_sel,
	output reg         io_sel,
	output reg         write_suppress,
	output reg         guard_break,
	output reg         tgt_wait,
	output reg         trace_en,
	// User pins, asynchronous
	input  wire        user_reset_in,
	input  wire        user_wait_in,
	input  wire        user_bus_request_in,
	input  wire        user_irq_edge_in,
	input  wire        wakeup_in,
	input  wire        sleep_entry,
	input  wire        break_in,
	input  wire        dma_req_in,
	// Gated outputs toward the target core
	output reg         cpu_reset,
	output reg         bus_request_input_pin,
	output reg         irq_to_cpu,
	output reg         resume_after_sleep,
	output reg         dma_grant,
	output reg         refresh_req,
	output reg         txd_start,
	output reg  [7:0]  serial_transmit_holding,
	output reg         trig_out_n
);

	// Run control
	reg [1:0]  run_q;
	reg [7:0]  exec_mode_q;
	reg        sleep_q;
	reg        after_sleep_q;
	reg        irq_pend_q;
	reg        host_warn_q;
	reg        fill_refused_q;
	reg        guard_hit_q;
	reg [15:0] watchdog_counter;
	reg [15:0] free_running_counter;
	reg [11:0] map_sel_q;
	reg [6:0]  trig_cnt_q;
	reg [9:0]  refresh_cnt_q;
	reg        running;

	// Per-block attribute map, one entry per 128 kbyte block of four areas
	reg [`ME_W-1:0] map_mem [0:`ATTR_ENTRIES-1];
	// Written flags: an entry never written reads as user memory, no RAM clear needed
	reg [`ATTR_ENTRIES-1:0] map_valid_q;

	// Pin synchronisers: stage one feeds stage two only
	reg [5:0] sync1_q;
	reg [5:0] sync2_q;
	reg       irq_prev_q;
	wire      s_rst  = sync2_q[0];
	wire      s_wait = sync2_q[1];
	wire      s_user_bus_request_in = sync2_q[2];
	wire      s_irq  = sync2_q[3];
	wire      s_wake = sync2_q[4];
	wire      s_dma  = sync2_q[5];

	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q    <= 6'h00;
			sync2_q    <= 6'h00;
			irq_prev_q <= 1'b0;
		end else begin
			sync1_q    <= {dma_req_in, wakeup_in, user_irq_edge_in, user_bus_request_in,
				user_wait_in, user_reset_in};
			sync2_q    <= sync1_q;
			irq_prev_q <= s_irq;
		end
	end

	always @* begin
		running = (run_q == `RUN_FREE) || (run_q == `RUN_STEP);
	end

	// AXI write: take address and data together, answer next cycle
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	wire rd_go = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;

	wire        io_host = (s_axi_wdata[31:28] == `IO_REGION_TOP);
	wire [11:0] tgt_blk = tgt_addr[28:`BLOCK_BITS];
	wire [`ME_W-1:0] ent = map_valid_q[tgt_blk] ? map_mem[tgt_blk] : {`ME_W{1'b0}};
	wire        is_io   = (tgt_addr[31:28] == `IO_REGION_TOP);
	wire        onchip  = is_io || (tgt_addr[31:28] == `ONCHIP_REGION_TOP);

	always @(posedge aclk) begin
		if (wr_go && s_axi_awaddr == `REG_MAP_DATA)
			map_mem[map_sel_q] <= s_axi_wdata[`ME_W-1:0];
	end

	// R1 unassigned blocks default to user memory
	always @(posedge aclk) begin
		if (!aresetn)
			map_valid_q <= {`ATTR_ENTRIES{1'b0}};
		else if (wr_go && s_axi_awaddr == `REG_MAP_DATA)
			map_valid_q[map_sel_q] <= 1'b1;
	end

	// Register writes and run state
	always @(posedge aclk) begin
		if (!aresetn) begin
			run_q          <= `RUN_WAIT;
			exec_mode_q    <= 8'h00;
			map_sel_q      <= 12'h000;
			host_warn_q    <= 1'b0;
			fill_refused_q <= 1'b0;
			s_axi_bvalid   <= 1'b0;
			s_axi_bresp    <= `AXI_OKAY;
			serial_transmit_holding <= 8'h00;
			txd_start      <= 1'b0;
			trig_cnt_q     <= 7'h00;
		end else begin
			txd_start <= 1'b0;
			if (trig_cnt_q != 7'h00)
				trig_cnt_q <= trig_cnt_q - 7'h01;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// R21 guard break
			if (guard_break || (break_in && running))
				run_q <= `RUN_WAIT;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `AXI_OKAY;
				case (s_axi_awaddr)
				`REG_RUN_CTRL: run_q <= s_axi_wdata[1:0];
				`REG_EXEC_MODE: exec_mode_q <= s_axi_wdata[7:0];
				`REG_MAP_SEL: map_sel_q <= s_axi_wdata[11:0];
				`REG_MAP_DATA: ;
				`REG_HOST_ACC: begin
					// R7 fill refused
					if (s_axi_wdata[`HA_FILL] && io_host) begin
						fill_refused_q <= 1'b1;
						s_axi_bresp    <= `AXI_SLVERR;
					// R6 warn no verify
					end else if (s_axi_wdata[`HA_WRITE] && io_host)
						host_warn_q <= 1'b1;
				end
				// R16 host transmit write
				`REG_STATUS: begin
					serial_transmit_holding <= s_axi_wdata[7:0];
					txd_start <= 1'b1;
				end
				// R20 trigger pulse
				`REG_TRIG: trig_cnt_q <= TRIG_LEN[6:0];
				`REG_WDT: ;
				`REG_FRT: ;
				default: s_axi_bresp <= `AXI_SLVERR;
				endcase
			end
		end
	end

	// Counters
	always @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_counter     <= 16'h0000;
			free_running_counter <= 16'h0000;
			refresh_cnt_q        <= 10'h000;
			refresh_req          <= 1'b0;
		end else begin
			// R14 watchdog gated
			if (wr_go && s_axi_awaddr == `REG_WDT)
				watchdog_counter <= s_axi_wdata[15:0];
			else if (running)
				watchdog_counter <= watchdog_counter + 16'h0001;
			// R15 always counting
			if (wr_go && s_axi_awaddr == `REG_FRT)
				free_running_counter <= s_axi_wdata[15:0];
			else
				free_running_counter <= free_running_counter + 16'h0001;
			// R19 continuous refresh
			refresh_cnt_q <= refresh_cnt_q + 10'h001;
			refresh_req   <= (refresh_cnt_q == 10'h3ff);
		end
	end

	// Sleep, interrupts and gated pins
	always @(posedge aclk) begin
		if (!aresetn) begin
			sleep_q       <= 1'b0;
			after_sleep_q <= 1'b0;
			irq_pend_q    <= 1'b0;
			irq_to_cpu    <= 1'b0;
			cpu_reset     <= 1'b0;
			bus_request_input_pin <= 1'b0;
			dma_grant     <= 1'b0;
			resume_after_sleep <= 1'b0;
			trig_out_n    <= 1'b1;
		end else begin
			// R8 wake or break ends sleep
			// R10 host access wakes
			if (sleep_q && (s_wake || break_in || guard_break ||
				(wr_go && s_axi_awaddr == `REG_HOST_ACC))) begin
				sleep_q       <= 1'b0;
				after_sleep_q <= 1'b1;
			end else if (sleep_entry && running)
				sleep_q <= 1'b1;
			// R9 resume after sleep
			resume_after_sleep <= 1'b0;
			if (after_sleep_q && running) begin
				resume_after_sleep <= 1'b1;
				after_sleep_q      <= 1'b0;
			end
			// R11 latch edge, dispatch in free-run
			irq_to_cpu <= 1'b0;
			if (run_q == `RUN_FREE && irq_pend_q) begin
				irq_to_cpu <= 1'b1;
				irq_pend_q <= s_irq && !irq_prev_q;
			end else if (s_irq && !irq_prev_q) begin
				if (run_q == `RUN_FREE)
					irq_to_cpu <= 1'b1;
				else
					irq_pend_q <= 1'b1;
			end
			// R12 reset only in free-run
			cpu_reset <= s_rst && (run_q == `RUN_FREE);
			// R13 bus request gated and maskable
			bus_request_input_pin <= s_user_bus_request_in && running && !exec_mode_q[`EM_MASK_USER_BUS_REQUEST_IN];
			// R17 DMA in all states
			dma_grant <= s_dma;
			trig_out_n <= !(trig_cnt_q != 7'h00);
		end
	end

	// Target access decode, registered one cycle after request
	always @(posedge aclk) begin
		if (!aresetn) begin
			emu_sel        <= 1'b0;
			emu_slot       <= 2'd0;
			user_sel       <= 1'b0;
			io_sel         <= 1'b0;
			write_suppress <= 1'b0;
			guard_break    <= 1'b0;
			guard_hit_q    <= 1'b0;
			tgt_wait       <= 1'b0;
			trace_en       <= 1'b0;
		end else begin
			// R5 on-chip I/O wins
			io_sel   <= tgt_req && is_io;
			// R1 block lookup
			emu_sel  <= tgt_req && !onchip && ent[`ME_EMU];
			emu_slot <= ent[1:0];
			user_sel <= tgt_req && !onchip && !ent[`ME_EMU];
			// R3 R4 external only
			write_suppress <= tgt_req && tgt_write && !onchip && ent[`ME_WP];
			guard_break    <= tgt_req && !onchip && ent[`ME_GUARD];
			if (tgt_req && !onchip && ent[`ME_GUARD])
				guard_hit_q <= 1'b1;
			else if (wr_go && s_axi_awaddr == `REG_STATUS)
				guard_hit_q <= 1'b0;
			// R2 R18 wait policy
			tgt_wait <= tgt_req && !onchip && ((tgt_prog_waits != 4'h0) ||
				(s_wait && running && (!ent[`ME_EMU] || exec_mode_q[`EM_WAIT_EMU])));
			// R8 no trace in sleep
			trace_en <= tgt_req && running && !sleep_q;
		end
	end

	// AXI read
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `AXI_OKAY;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `AXI_OKAY;
				case (s_axi_araddr)
				`REG_RUN_CTRL:  s_axi_rdata <= {30'h0, run_q};
				`REG_EXEC_MODE: s_axi_rdata <= {24'h0, exec_mode_q};
				`REG_STATUS:    s_axi_rdata <= {26'h0, guard_hit_q, fill_refused_q,
					host_warn_q, irq_pend_q, after_sleep_q, sleep_q};
				`REG_MAP_SEL:   s_axi_rdata <= {20'h0, map_sel_q};
				`REG_MAP_DATA:  s_axi_rdata <= {26'h0, map_valid_q[map_sel_q] ?
					map_mem[map_sel_q] : 6'h00};
				`REG_WDT:       s_axi_rdata <= {16'h0, watchdog_counter};
				`REG_FRT:       s_axi_rdata <= {16'h0, free_running_counter};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `AXI_SLVERR;
				end
				endcase
			end
		end
	end

endmodule // emu_map_gate

// *** emu_map_checker.sv ***
// Port-level checks for the emulator memory map and run gating block.
// Assumes it is bound to emu_map_gate and sees only that module's ports.
`timescale 1ns/1ps
module emu_map_checker #(
	parameter TRIG_LEN = 20
) (
	input logic		aclk,
	input logic		aresetn,
	input logic		s_axi_awvalid,
	input logic		s_axi_awready,
	input logic		s_axi_wvalid,
	input logic		s_axi_wready,
	input logic		s_axi_bvalid,
	input logic		s_axi_bready,
	input logic		s_axi_arvalid,
	input logic		s_axi_arready,
	input logic		s_axi_rvalid,
	input logic		s_axi_rready,
	input logic		tgt_req,
	input logic [31:0]	tgt_addr,
	input logic		emu_sel,
	input logic		user_sel,
	input logic		io_sel,
	input logic		write_suppress,
	input logic		guard_break,
	input logic		refresh_req,
	input logic		trig_out_n
);
	int unsigned	low_q;
	int unsigned	ref_q;
	logic		seen_q;

	// Trigger low time and refresh spacing; the first refresh has no reference
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_q <= 0;
			ref_q <= 0;
			seen_q <= 1'b0;
		end else begin
			low_q <= trig_out_n ? 0 : low_q + 1;
			ref_q <= refresh_req ? 0 : ref_q + 1;
			seen_q <= seen_q | refresh_req;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
	endsequence
	sequence s_io_hit;
		tgt_req && tgt_addr[31:28] == 4'hf;
	endsequence

	chk_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
		else $error("write response missing");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid)
		else $error("read response missing");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped early");
	chk_io_route: assert property (s_io_hit |=> io_sel && !emu_sel && !user_sel)
		else $error("on-chip I/O access not routed inside");
	chk_onchip_noattr: assert property (tgt_req && tgt_addr[31:29] == 3'h7 |=> !write_suppress && !guard_break)
		else $error("attribute acted on on-chip address");
	chk_ext_oneof: assert property (tgt_req && tgt_addr[31:29] == 3'h0 |=> emu_sel != user_sel)
		else $error("external block not mapped to exactly one memory");
	chk_trig_width: assert property ($rose(trig_out_n) |-> low_q == TRIG_LEN)
		else $error("trigger pulse width wrong");
	chk_refresh_gap: assert property (refresh_req && seen_q |-> ref_q == 1023)
		else $error("refresh spacing wrong");
	chk_refresh_due: assert property (ref_q < (seen_q ? 1024 : 1025))
		else $error("refresh missed");
endmodule // emu_map_checker

bind emu_map_gate emu_map_checker #(.TRIG_LEN(TRIG_LEN)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.tgt_req(tgt_req), .tgt_addr(tgt_addr), .emu_sel(emu_sel), .user_sel(user_sel),
	.io_sel(io_sel), .write_suppress(write_suppress), .guard_break(guard_break),
	.refresh_req(refresh_req), .trig_out_n(trig_out_n));

// *** emu_user_board.sv ***
// Model of the user target board that drives the asynchronous user pins.
// Assumes the bench asks for pin levels through set_pins.
`timescale 1ns/1ps
module emu_user_board (
	input logic	aclk,
	output logic	user_reset_in,
	output logic	user_wait_in,
	output logic	user_bus_request_in,
	output logic	user_irq_edge_in,
	output logic	wakeup_in,
	output logic	dma_req_in
);
	// Pins idle low; changes land just after an edge like clocked board logic
	initial {user_reset_in, user_wait_in, user_bus_request_in, user_irq_edge_in, wakeup_in,
		dma_req_in} = 6'h00;
	task automatic set_pins(input logic [5:0] v);
		@(posedge aclk);
		{user_reset_in, user_wait_in, user_bus_request_in, user_irq_edge_in, wakeup_in,
			dma_req_in} <= v;
	endtask
endmodule // emu_user_board

// *** emu_map_gate_tb_top.sv ***
// Self-checking bench for the memory map and run gating block.
// Assumes the checker is bound in and the board model drives the user pins.
`timescale 1ns/1ps
`include "emu_map_consts.vh"
module emu_map_gate_tb_top;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, tgt_req = 0, tgt_write = 0;
	logic sleep_entry = 0, break_in = 0, clr = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, tgt_addr = 0, s_axi_rdata, d0, d1, d2;
	logic [3:0] s_axi_wstrb = 4'hf, tgt_prog_waits = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, emu_slot;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic emu_sel, user_sel, io_sel, write_suppress, guard_break, tgt_wait, trace_en;
	logic user_reset_in, user_wait_in, user_bus_request_in, user_irq_edge_in, wakeup_in;
	logic dma_req_in, cpu_reset, bus_request_input_pin, irq_to_cpu, resume_after_sleep;
	logic dma_grant, refresh_req, txd_start, trig_out_n;
	logic [7:0] serial_transmit_holding;
	logic [7:0] seen = 0;
	int err_count = 0, checked = 0, cyc = 0, i;
	// Rows: address, write, expected {slot,emu,user,io,suppress,guard}, mask
	logic [46:0] rows [6] = '{{32'h00000000, 1'b1, 7'h32, 7'h7f},
		{32'h00000000, 1'b0, 7'h30, 7'h7f}, {32'h00040000, 1'b1, 7'h08, 7'h1f},
		{32'hf0000000, 1'b1, 7'h04, 7'h1f}, {32'he0000000, 1'b1, 7'h00, 7'h03},
		{32'h00020000, 1'b0, 7'h01, 7'h03}};

	emu_map_gate #(.TRIG_LEN(2)) u_dut (.*);
	emu_user_board u_board (.*);

	// Clock, plus a cycle ceiling so a hang still ends in the verdict
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 10000) begin
			err_count++;
			print_verdict();
		end
	end
	// Sticky record of pulses that are too short to poll reliably
	always @(posedge aclk)
		seen <= clr ? 8'h00 : seen | {resume_after_sleep, !trig_out_n, dma_grant,
			bus_request_input_pin,
			cpu_reset, refresh_req, txd_start, irq_to_cpu};

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		s_axi_bready <= 1;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk(s_axi_bresp, er);
		@(posedge aclk);
	endtask
	task axr(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		d = s_axi_rdata;
		chk(s_axi_rresp, er);
		@(posedge aclk);
	endtask
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence: map decode table, then gating of user pins across run states
	initial begin
		wt(10);
		aresetn <= 1;
		wt(1);
		chk({cpu_reset, bus_request_input_pin, irq_to_cpu, dma_grant, trig_out_n}, 32'h1);
		axr(12'hffc, d0, `AXI_SLVERR);
		axr(`REG_FRT, d0, `AXI_OKAY);
		axr(`REG_WDT, d1, `AXI_OKAY);
		wt(20);
		axr(`REG_FRT, d2, `AXI_OKAY);
		chk(d2 != d0, 1);
		axr(`REG_WDT, d0, `AXI_OKAY);
		chk(d0, d1);
		axw(`REG_MAP_SEL, 0, `AXI_OKAY);
		axw(`REG_MAP_DATA, 32'h19, `AXI_OKAY);
		axw(`REG_MAP_SEL, 1, `AXI_OKAY);
		axw(`REG_MAP_DATA, 32'h20, `AXI_OKAY);
		axw(`REG_MAP_SEL, 32'h800, `AXI_OKAY);
		axw(`REG_MAP_DATA, 32'h38, `AXI_OKAY);
		for (i = 0; i < 6; i++) begin
			{tgt_addr, tgt_write} <= rows[i][46:14];
			tgt_req <= 1;
			@(posedge aclk);
			tgt_req <= 0;
			#1;
			chk({emu_slot, emu_sel, user_sel, io_sel, write_suppress, guard_break} & rows[i][6:0], rows[i][13:7]);
			@(posedge aclk);
		end
		axw(`REG_HOST_ACC, 32'hf0000001, `AXI_OKAY);
		axw(`REG_HOST_ACC, 32'hf0000002, `AXI_SLVERR);
		axw(`REG_HOST_ACC, 32'h00000002, `AXI_OKAY);
		axr(`REG_STATUS, d0, `AXI_OKAY);
		chk(d0, 32'h38);
		u_board.set_pins(6'h2d);
		u_board.set_pins(6'h2d);
		u_board.set_pins(6'h29);
		wt(8);
		chk({seen[0], cpu_reset, bus_request_input_pin, dma_grant}, 32'h1);
		axw(`REG_RUN_CTRL, 1, `AXI_OKAY);
		axr(`REG_WDT, d0, `AXI_OKAY);
		wt(6);
		axr(`REG_WDT, d1, `AXI_OKAY);
		chk(d0 != d1, 1);
		chk({seen[0], cpu_reset, bus_request_input_pin}, 32'h7);
		axw(`REG_EXEC_MODE, 1, `AXI_OKAY);
		wt(4);
		chk(bus_request_input_pin, 0);
		axw(`REG_RUN_CTRL, 2, `AXI_OKAY);
		wt(4);
		chk(cpu_reset, 0);
		axw(`REG_STATUS, 32'h5a, `AXI_OKAY);
		chk({seen[1], serial_transmit_holding}, 32'h15a);
		axw(`REG_TRIG, 0, `AXI_OKAY);
		wt(4);
		chk(seen[6], 1);
		// Sleep while stepping: no trace, break wakes, resume pulse on restart
		sleep_entry <= 1;
		@(posedge aclk);
		sleep_entry <= 0;
		tgt_addr <= 32'h00040000;
		tgt_prog_waits <= 4'h1;
		tgt_req <= 1;
		@(posedge aclk);
		tgt_req <= 0;
		#1;
		chk({trace_en, tgt_wait}, 32'h1);
		axr(`REG_STATUS, d0, `AXI_OKAY);
		chk(d0, 32'h19);
		break_in <= 1;
		@(posedge aclk);
		break_in <= 0;
		axr(`REG_STATUS, d0, `AXI_OKAY);
		chk(d0, 32'h1a);
		axw(`REG_RUN_CTRL, 1, `AXI_OKAY);
		wt(2);
		chk(seen[7], 1);
		u_board.set_pins(6'h00);
		// Two refresh periods so the spacing check sees a full gap
		repeat (2) begin
			clr <= 1;
			wt(1);
			clr <= 0;
			for (i = 0; i < 1100 && !seen[2]; i++) wt(1);
			chk(seen[2], 1);
		end
		print_verdict();
	end
endmodule // emu_map_gate_tb_top
